//--- ext_mem_strobe_control.sv
// strobe, select and data-direction control for external static memory
// How it works
// - read strobe low, data pins become inputs
// - read data latched as read strobe rises
// - selects valid from setup through hold, framing the strobe
// - idle read strobe floats or drives per control
// - write strobe low, write data driven out
// - idle write strobe floats or drives per control
// - program select low for program memory accesses
// - chip select zero resets as program select
// - idle chip select zero floats or drives
// - pull-up disable bit kills strobe pull-ups
// - program pin usable as GPIO, own pull-up
// - data select low for data accesses, reset default
`timescale 1ns/100ps
`include "emsc_defines.svh"

module ext_mem_strobe_control
  import emsc_pkg::*;
#(
  parameter int DATA_WIDTH = `EMSC_DATA_WIDTH,
  parameter int STROBE_CYC = `EMSC_STROBE_CYC
) (
  input  wire logic                  clk_sys,             // system clock, 125 MHz
  input  wire logic                  srst,                // synchronous reset, active high
  input  wire logic                  clk_en,              // clock enable, freezes state when low
  input  wire logic                  acc_req,             // start an external access
  input  wire logic                  acc_write,           // 1 write, 0 read
  input  wire logic                  acc_prog,            // 1 program space, 0 data space
  input  wire logic [1:0]            acc_cs_hit,          // generic chip select decode hits
  input  wire logic [DATA_WIDTH-1:0] acc_wdata,           // write data
  output logic                       acc_ready,           // idle, request accepted
  output logic [DATA_WIDTH-1:0]      rd_data,             // latched read data
  output logic                       rd_valid,            // read data updated, one cycle
  input  wire logic                  bus_drive_ctl,       // drive controls while idle
  input  wire logic                  cs_cfg_we,           // load chip select function
  input  wire logic                  cs_cfg_ps_mode,      // chip select zero acts as program sel
  input  wire logic                  cs_cfg_ds_mode,      // chip select one acts as data sel
  input  wire logic                  ctrl_pullup_disable, // strobe pull-up disable bit
  input  wire logic [`EMSC_PUR_WIDTH-1:0] port_pullup_reg, // port pull-up enables
  input  wire logic                  prog_pin_gpio_en,    // program select pin used as GPIO
  input  wire logic                  prog_pin_gpio_dir,   // GPIO direction, 1 output
  input  wire logic                  prog_pin_gpio_out,   // GPIO output level
  output logic                       prog_pin_gpio_in,    // GPIO sampled input
  output logic                       read_strobe_n_o,     // read strobe level
  output logic                       read_strobe_n_oe,    // read strobe driven
  output logic                       write_strobe_n_o,    // write strobe level
  output logic                       write_strobe_n_oe,   // write strobe driven
  output logic                       program_space_select_n_o,  // chip select zero level
  output logic                       program_space_select_n_oe, // chip select zero driven
  input  wire logic                  program_space_select_n_i,  // chip select zero pin input
  output logic                       data_space_select_n_o,     // chip select one level
  output logic                       data_space_select_n_oe,    // chip select one driven
  input  wire logic [DATA_WIDTH-1:0] ext_data_pins_i,     // data pins input
  output logic [DATA_WIDTH-1:0]      ext_data_pins_o,     // data pins output
  output logic                       ext_data_pins_oe,    // data pins driven
  output logic                       strobe_pullup_en,    // pull-up on both strobe pins
  output logic                       prog_pin_pullup_en   // pull-up on program select pin
);

  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);

  emsc_state_type        state_q;
  emsc_state_type        state_d;
  logic [7:0]            cnt_q;
  logic [7:0]            cnt_d;
  logic                  is_wr_q;
  logic                  is_prog_q;
  logic [1:0]            hit_q;
  logic                  cs0_ps_mode_q;
  logic                  cs1_ds_mode_q;
  logic                  data_oe_q;
  logic [DATA_WIDTH-1:0] wdata_q;
  logic [DATA_WIDTH-1:0] rdata_q;
  logic                  rd_valid_q;
  logic                  gpio_in_q;
  logic                  cs0_pad_o;
  logic                  cs0_pad_oe;

  wire take      = acc_req && (state_q == EMSC_ST_IDLE);
  wire is_wr_d   = take ? acc_write : is_wr_q;
  wire is_prog_d = take ? acc_prog : is_prog_q;
  wire [1:0] hit_d = take ? acc_cs_hit : hit_q;
  wire active_d  = (state_d != EMSC_ST_IDLE);
  wire strobe_d  = (state_d == EMSC_ST_STROBE);
  // selects span setup, strobe and hold so they frame the strobe edges
  wire rd_assert_d  = strobe_d && !is_wr_d;
  wire wr_assert_d  = strobe_d && is_wr_d;
  wire cs0_assert_d = cs0_ps_mode_q ? is_prog_d : hit_d[0];
  wire cs1_assert_d = cs1_ds_mode_q ? !is_prog_d : hit_d[1];
  wire rd_rise   = (state_q == EMSC_ST_STROBE) && (state_d == EMSC_ST_HOLD) && !is_wr_q;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      EMSC_ST_IDLE: begin
        if (acc_req) begin
          state_d = EMSC_ST_SETUP;
        end
      end
      EMSC_ST_SETUP: begin
        state_d = EMSC_ST_STROBE;
        cnt_d   = 8'h00;
      end
      EMSC_ST_STROBE: begin
        if (cnt_q >= STROBE_LAST) begin
          state_d = EMSC_ST_HOLD;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      EMSC_ST_HOLD: begin
        state_d = EMSC_ST_IDLE;
      end
      default: begin
        state_d = EMSC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q   <= EMSC_ST_IDLE;
      cnt_q     <= 8'h00;
      is_wr_q   <= 1'b0;
      is_prog_q <= 1'b0;
      hit_q     <= 2'h0;
    end else if (clk_en) begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      is_wr_q   <= is_wr_d;
      is_prog_q <= is_prog_d;
      hit_q     <= hit_d;
    end
  end

  // chip select functions restart as the legacy program and data selects
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cs0_ps_mode_q <= `EMSC_CS0_PS_RST;
      cs1_ds_mode_q <= `EMSC_CS1_DS_RST;
    end else if (clk_en && cs_cfg_we) begin
      cs0_ps_mode_q <= cs_cfg_ps_mode;
      cs1_ds_mode_q <= cs_cfg_ds_mode;
    end
  end

  // write data is held after the strobe rises; only the enable drops
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      data_oe_q  <= 1'b0;
      wdata_q    <= '0;
      rdata_q    <= '0;
      rd_valid_q <= 1'b0;
      gpio_in_q  <= 1'b0;
    end else if (clk_en) begin
      data_oe_q  <= wr_assert_d;
      if (take && acc_write) begin
        wdata_q <= acc_wdata;
      end
      if (rd_rise) begin
        rdata_q <= ext_data_pins_i;
      end
      rd_valid_q <= rd_rise;
      gpio_in_q  <= program_space_select_n_i;
    end
  end

  emsc_strobe_pad u_rd_pad (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .clk_en    (clk_en),
    .assert_d  (rd_assert_d),
    .active_d  (active_d),
    .drive_ctl (bus_drive_ctl),
    .pin_o     (read_strobe_n_o),
    .pin_oe    (read_strobe_n_oe)
  );

  emsc_strobe_pad u_wr_pad (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .clk_en    (clk_en),
    .assert_d  (wr_assert_d),
    .active_d  (active_d),
    .drive_ctl (bus_drive_ctl),
    .pin_o     (write_strobe_n_o),
    .pin_oe    (write_strobe_n_oe)
  );

  emsc_strobe_pad u_cs0_pad (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .clk_en    (clk_en),
    .assert_d  (cs0_assert_d),
    .active_d  (active_d),
    .drive_ctl (bus_drive_ctl),
    .pin_o     (cs0_pad_o),
    .pin_oe    (cs0_pad_oe)
  );

  emsc_strobe_pad u_cs1_pad (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .clk_en    (clk_en),
    .assert_d  (cs1_assert_d),
    .active_d  (active_d),
    .drive_ctl (bus_drive_ctl),
    .pin_o     (data_space_select_n_o),
    .pin_oe    (data_space_select_n_oe)
  );

  // gpio use of the program select pin still floats while in reset
  assign program_space_select_n_o  = prog_pin_gpio_en ? prog_pin_gpio_out : cs0_pad_o;
  assign program_space_select_n_oe = prog_pin_gpio_en ? (prog_pin_gpio_dir && !srst)
                                                      : cs0_pad_oe;
  assign prog_pin_gpio_in   = gpio_in_q;
  assign prog_pin_pullup_en = port_pullup_reg[`EMSC_PUR_PROG_BIT];
  assign strobe_pullup_en   = !ctrl_pullup_disable;
  assign ext_data_pins_o    = wdata_q;
  assign ext_data_pins_oe   = data_oe_q;
  assign rd_data            = rdata_q;
  assign rd_valid           = rd_valid_q;
  assign acc_ready          = (state_q == EMSC_ST_IDLE);

  wire rd_low  = read_strobe_n_oe && !read_strobe_n_o;
  wire wr_low  = write_strobe_n_oe && !write_strobe_n_o;

  property p_rd_inputs;
    @(posedge clk_sys) disable iff (srst) rd_low |-> !ext_data_pins_oe;
  endproperty
  a_rd_inputs: assert property (p_rd_inputs) else $error("data driven during read");

  property p_rd_capture;
    @(posedge clk_sys) disable iff (srst)
      (rd_low && clk_en && state_q == EMSC_ST_STROBE && cnt_q >= STROBE_LAST)
      |=> (rd_data == $past(ext_data_pins_i)) && rd_valid && read_strobe_n_o;
  endproperty
  a_rd_capture: assert property (p_rd_capture) else $error("read data not latched");

  property p_sel_valid;
    @(posedge clk_sys) disable iff (srst)
      (rd_low || wr_low) |-> data_space_select_n_oe && cs0_pad_oe;
  endproperty
  a_sel_valid: assert property (p_sel_valid) else $error("select not driven at strobe");

  property p_idle_drive;
    @(posedge clk_sys) disable iff (srst)
      (state_q == EMSC_ST_IDLE && $past(state_q == EMSC_ST_IDLE) && $past(clk_en)
       && !$past(srst))
      |-> read_strobe_n_oe == $past(bus_drive_ctl)
          && write_strobe_n_oe == $past(bus_drive_ctl)
          && cs0_pad_oe == $past(bus_drive_ctl);
  endproperty
  a_idle_drive: assert property (p_idle_drive) else $error("idle drive wrong");

  property p_wr_data;
    @(posedge clk_sys) disable iff (srst)
      wr_low |-> ext_data_pins_oe && $stable(ext_data_pins_o);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data not held");

  property p_ps_sel;
    @(posedge clk_sys) disable iff (srst)
      ((rd_low || wr_low) && cs0_ps_mode_q) |-> (cs0_pad_o == !is_prog_q);
  endproperty
  a_ps_sel: assert property (p_ps_sel) else $error("program select wrong");

  property p_reset_float;
    @(posedge clk_sys)
      srst |=> !read_strobe_n_oe && !write_strobe_n_oe && !cs0_pad_oe
                      && cs0_ps_mode_q && cs1_ds_mode_q;
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("reset state wrong");

  property p_exclusive;
    @(posedge clk_sys) disable iff (srst)
      !(rd_low && wr_low) && (!ext_data_pins_oe || wr_low);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("strobes overlap");

endmodule

//--- emsc_defines.svh
// constants for the external memory strobe controller
`ifndef EMSC_DEFINES_SVH
`define EMSC_DEFINES_SVH

`define EMSC_CLK_PERIOD_NS   8
`define EMSC_STROBE_NS       16
`define EMSC_STROBE_CYC      ((`EMSC_STROBE_NS + `EMSC_CLK_PERIOD_NS - 1) / `EMSC_CLK_PERIOD_NS)
`define EMSC_DATA_WIDTH      16
`define EMSC_PUR_PROG_BIT    8
`define EMSC_PUR_WIDTH       16
`define EMSC_CS0_PS_RST      1'b1
`define EMSC_CS1_DS_RST      1'b1
`define EMSC_STROBE_IDLE     1'b1

`endif

//--- emsc_pkg.sv
// types for the external memory strobe controller
package emsc_pkg;

  typedef enum logic [3:0] {
    EMSC_ST_IDLE   = 4'h1,
    EMSC_ST_SETUP  = 4'h2,
    EMSC_ST_STROBE = 4'h4,
    EMSC_ST_HOLD   = 4'h8
  } emsc_state_type;

endpackage

//--- emsc_strobe_pad.sv
// registered pad driver for one active-low control strobe or select
`timescale 1ns/100ps
`include "emsc_defines.svh"

module emsc_strobe_pad (
  input  wire logic clk_sys,    // system clock
  input  wire logic srst,       // synchronous reset, active high
  input  wire logic clk_en,     // clock enable
  input  wire logic assert_d,   // strobe asserted next cycle
  input  wire logic active_d,   // bus cycle in progress next cycle
  input  wire logic drive_ctl,  // keep driving while the bus is idle
  output logic      pin_o,      // pin level
  output logic      pin_oe      // pin driven
);

  logic pin_o_d;
  logic pin_oe_d;

  // idle pin parks high, driven only when drive_ctl asks for it
  assign pin_o_d  = active_d ? ~assert_d : `EMSC_STROBE_IDLE;
  assign pin_oe_d = active_d | drive_ctl;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_o  <= `EMSC_STROBE_IDLE;
      pin_oe <= 1'b0;
    end else if (clk_en) begin
      pin_o  <= pin_o_d;
      pin_oe <= pin_oe_d;
    end
  end

endmodule

//--- emsc_mem_model.sv
// behavioural static memory standing on the far side of the strobe controller
`timescale 1ns/100ps

module emsc_mem_model (
  input  wire logic        clk_sys,  // system clock
  input  wire logic        rd_n,     // read strobe wire level
  input  wire logic        wr_n,     // write strobe wire level
  input  wire logic        ps_n,     // program select wire level
  input  wire logic        ds_n,     // data select wire level
  input  wire logic [15:0] din,      // data bus seen by the memory
  output logic      [15:0] dout,     // data the memory drives
  output logic             dout_oe   // memory drives the bus
);
  // one word per space, since the block carries no address pins
  logic [15:0] mem [2];
  logic [15:0] wbuf_q;
  logic [15:0] last_q = 16'hA5A5;
  logic        wr_q = 1'h1;
  wire         sel_w = !ps_n || !ds_n;
  // data is taken while the strobe is low and committed at its rise, so the
  // device dropping its drive on that same edge does not race the capture
  always @(posedge clk_sys) begin
    wr_q <= wr_n;
    if (!wr_n && sel_w) wbuf_q <= din;
    if (wr_n && !wr_q && sel_w) mem[ps_n] <= wbuf_q;
    if (dout_oe) last_q <= dout;
  end
  assign dout_oe = !rd_n && sel_w;
  // a released bus shows the inverse of the last word, never a stale copy
  assign dout = dout_oe ? mem[ps_n] : ~last_q;
endmodule

//--- ext_mem_strobe_control_bench.sv
// self-checking bench for the external memory strobe controller
`timescale 1ns/100ps

module ext_mem_strobe_control_bench;
  localparam int SC = 2;
  logic clk_sys = 1'h0, srst = 1'h1, clk_en = 1'h1, acc_req = 1'h0, acc_write = 1'h0;
  logic acc_prog = 1'h0, bus_drive_ctl = 1'h0, cs_cfg_we = 1'h0, cs_cfg_ps_mode = 1'h1;
  logic cs_cfg_ds_mode = 1'h1, ctrl_pullup_disable = 1'h0, prog_pin_gpio_en = 1'h0;
  logic prog_pin_gpio_dir = 1'h0, prog_pin_gpio_out = 1'h0, program_space_select_n_i = 1'h1;
  logic [1:0] acc_cs_hit = 2'h0;
  logic [15:0] acc_wdata = 16'h0000, port_pullup_reg = 16'h0000;
  logic acc_ready, rd_valid, prog_pin_gpio_in, read_strobe_n_o, read_strobe_n_oe;
  logic write_strobe_n_o, write_strobe_n_oe, program_space_select_n_o, mem_oe;
  logic program_space_select_n_oe, data_space_select_n_o, data_space_select_n_oe;
  logic ext_data_pins_oe, strobe_pullup_en, prog_pin_pullup_en;
  logic [15:0] rd_data, ext_data_pins_o, mem_dout;
  wire [15:0] ext_data_pins_i = ext_data_pins_oe ? ext_data_pins_o : mem_dout;
  // undriven strobes and selects rest high, as the pin pull-ups hold them
  wire rd_w = read_strobe_n_oe ? read_strobe_n_o : 1'h1;
  wire wr_w = write_strobe_n_oe ? write_strobe_n_o : 1'h1;
  wire ps_w = program_space_select_n_oe ? program_space_select_n_o : 1'h1;
  wire ds_w = data_space_select_n_oe ? data_space_select_n_o : 1'h1;
  wire [2:0] oe3 = {read_strobe_n_oe, write_strobe_n_oe, program_space_select_n_oe};
  int fails = 0;
  int compares = 0;

  ext_mem_strobe_control #(.DATA_WIDTH(16), .STROBE_CYC(SC)) dut_u (.*);
  emsc_mem_model mem_u (.clk_sys(clk_sys), .rd_n(rd_w), .wr_n(wr_w), .ps_n(ps_w),
    .ds_n(ds_w), .din(ext_data_pins_i), .dout(mem_dout), .dout_oe(mem_oe));

  always #4 clk_sys = ~clk_sys;

  task automatic ck(input bit ok, input string m);
    compares++;
    if (!ok) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // one access; c0/c1 give which selects must be low while a strobe is low
  task automatic acc(input logic w, input logic p, input logic [1:0] hit,
                     input logic [15:0] d, input logic c0, input logic c1);
    int nlow;
    int nval;
    bit rl;
    bit wl;
    nlow = 0;
    nval = 0;
    @(posedge clk_sys);
    acc_req <= 1'h1;
    acc_write <= w;
    acc_prog <= p;
    acc_cs_hit <= hit;
    acc_wdata <= d;
    @(posedge clk_sys);
    acc_req <= 1'h0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      #1;
      if (acc_ready === 1'h1) break;
      rl = read_strobe_n_oe === 1'h1 && read_strobe_n_o === 1'h0;
      wl = write_strobe_n_oe === 1'h1 && write_strobe_n_o === 1'h0;
      nlow += int'(rl || wl);
      nval += int'(rd_valid === 1'h1);
      ck(!(rl && wl), "strobes overlap");
      ck(ext_data_pins_oe === wl, "data drive");
      if (wl) ck(ext_data_pins_o === d, "write data");
      if (rl || wl) ck(rl == !w, "strobe kind");
      if (rl || wl) ck({ps_w, ds_w} === {!c0, !c1}, "selects");
    end
    ck(acc_ready === 1'h1 && ext_data_pins_oe === 1'h0, "end of access");
    ck(nlow == SC, "strobe width");
    if (!w) ck(nval == 1 && rd_data === d, "read data");
  endtask

  task automatic t_rw();
    acc(1'h1, 1'h1, 2'h0, 16'hC3A5, 1'h1, 1'h0);
    acc(1'h1, 1'h0, 2'h0, 16'h5A3C, 1'h0, 1'h1);
    acc(1'h0, 1'h1, 2'h0, 16'hC3A5, 1'h1, 1'h0);
    acc(1'h0, 1'h0, 2'h0, 16'h5A3C, 1'h0, 1'h1);
  endtask

  task automatic t_idle(input logic drv);
    @(posedge clk_sys);
    bus_drive_ctl <= drv;
    repeat (2) @(posedge clk_sys);
    #1;
    ck(oe3 === {3{drv}}, "idle drive");
    ck(!drv || {rd_w, wr_w, ps_w} === 3'h7, "idle level");
    t_rw();
  endtask

  task automatic t_pull();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      ctrl_pullup_disable <= k[0];
      port_pullup_reg <= k[0] ? 16'h0100 : 16'hFEFF;
      @(posedge clk_sys);
      #1;
      ck(strobe_pullup_en === !k[0], "strobe pull-up");
      ck(prog_pin_pullup_en === k[0], "program pin pull-up");
    end
  endtask

  task automatic t_gpio();
    @(posedge clk_sys);
    prog_pin_gpio_en <= 1'h1;
    prog_pin_gpio_dir <= 1'h1;
    program_space_select_n_i <= 1'h0;
    repeat (2) @(posedge clk_sys);
    #1;
    ck({program_space_select_n_oe, program_space_select_n_o} === 2'h2, "gpio out");
    ck(prog_pin_gpio_in === 1'h0, "gpio in");
    @(posedge clk_sys);
    prog_pin_gpio_out <= 1'h1;
    @(posedge clk_sys);
    #1;
    ck({program_space_select_n_oe, program_space_select_n_o} === 2'h3, "gpio out high");
    @(posedge clk_sys);
    prog_pin_gpio_dir <= 1'h0;
    @(posedge clk_sys);
    #1;
    ck(program_space_select_n_oe === 1'h0, "gpio input mode");
    @(posedge clk_sys);
    prog_pin_gpio_en <= 1'h0;
  endtask

  // chip select zero leaves program duty only when reconfigured
  task automatic t_cfg();
    @(posedge clk_sys);
    cs_cfg_we <= 1'h1;
    cs_cfg_ps_mode <= 1'h0;
    @(posedge clk_sys);
    cs_cfg_we <= 1'h0;
    acc(1'h1, 1'h1, 2'h0, 16'h0F0F, 1'h0, 1'h0);
    acc(1'h1, 1'h0, 2'h1, 16'h0F0F, 1'h1, 1'h1);
  endtask

  // a program read frozen in setup by the clock enable, then let run to its end
  task automatic t_freeze();
    @(posedge clk_sys);
    acc_req <= 1'h1;
    acc_write <= 1'h0;
    acc_prog <= 1'h1;
    @(posedge clk_sys);
    acc_req <= 1'h0;
    clk_en <= 1'h0;
    repeat (4) @(posedge clk_sys);
    #1;
    ck(acc_ready === 1'h0 && read_strobe_n_o === 1'h1 && ps_w === 1'h0, "freeze");
    @(posedge clk_sys);
    clk_en <= 1'h1;
    repeat (5) @(posedge clk_sys);
    #1;
    ck(acc_ready === 1'h1 && rd_data === 16'hC3A5, "resume read");
  endtask

  // reset in mid-run floats the pins, gpio use included, and restores select duty
  task automatic t_rst();
    @(posedge clk_sys);
    srst <= 1'h1;
    prog_pin_gpio_en <= 1'h1;
    prog_pin_gpio_dir <= 1'h1;
    repeat (2) @(posedge clk_sys);
    #1;
    ck(oe3 === 3'h0, "mid-run reset float");
    @(posedge clk_sys);
    srst <= 1'h0;
    prog_pin_gpio_en <= 1'h0;
    acc(1'h0, 1'h1, 2'h0, 16'h0F0F, 1'h1, 1'h0);
  endtask

  initial begin
    repeat (9) @(posedge clk_sys);
    #1;
    ck(oe3 === 3'h0, "reset float");
    ck(acc_ready === 1'h1 && rd_valid === 1'h0, "reset state");
    @(posedge clk_sys);
    srst <= 1'h0;
    t_idle(1'h0);
    t_idle(1'h1);
    t_pull();
    t_gpio();
    t_freeze();
    t_cfg();
    t_rst();
    tally_and_finish();
  end

  // the tests take some 110 cycles; this bound cuts a hang short
  initial begin
    #40000;
    fails++;
    tally_and_finish();
  end
endmodule
